/* core/pir_pkg.sv */
package pir_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_USER_REV = 8'h9B;
  localparam logic [7:0] CMD_SERIAL   = 8'h9E;
  localparam logic [7:0] CMD_DEV_ID   = 8'hAD;
  localparam logic [7:0] CMD_DEV_REV  = 8'hAE;

  // ----------------------------------------------------------------
  // Block payload lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] LEN_USER_REV = 8'h03;
  localparam logic [7:0] LEN_SERIAL   = 8'h03;
  localparam logic [7:0] LEN_DEV_ID   = 8'h06;
  localparam logic [7:0] LEN_DEV_REV  = 8'h02;

  // ----------------------------------------------------------------
  // Revision field positions
  // ----------------------------------------------------------------
  localparam int REV_MAJOR_MSB = 15;
  localparam int REV_MAJOR_LSB = 12;
  localparam int REV_MINOR_MSB = 11;
  localparam int REV_MINOR_LSB = 8;
  localparam int REV_SUB_MSB   = 7;
  localparam int REV_SUB_LSB   = 0;

  // ----------------------------------------------------------------
  // Identity values (arbitrary neutral values)
  // ----------------------------------------------------------------
  localparam logic [47:0] DEV_ID_VALUE    = 48'h0605_0403_0201;
  localparam logic [3:0]  REV_MAJOR_VALUE = 4'h1;
  localparam logic [3:0]  REV_MINOR_VALUE = 4'h0;
  localparam logic [7:0]  REV_SUB_VALUE   = 8'h00;

  // ----------------------------------------------------------------
  // Communication status layout and reset values
  // ----------------------------------------------------------------
  localparam int         INVALID_CMD_BIT   = 7;
  localparam int         INVALID_DATA_BIT  = 6;
  localparam logic [7:0] COMM_STATUS_RESET = 8'h00;
  localparam logic [7:0] CHECKSUM_RESET   = 8'h00;
  localparam logic [7:0] RD_FILL_BYTE     = 8'hFF;

  // ----------------------------------------------------------------
  // Non-volatile image layout
  // ----------------------------------------------------------------
  localparam logic [2:0] NVM_USER_REV_BASE = 3'h0;
  localparam logic [2:0] NVM_SERIAL_BASE   = 3'h3;
  localparam logic [2:0] NVM_LAST          = 3'h5;
  localparam int         NVM_DEPTH         = 6;

  typedef enum logic [1:0]
  {
    ST_LOAD  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_STORE = 2'b10
  } pir_state_type;

  typedef struct packed
  {
    logic [7:0] code;
    logic       write;
  } pir_txn_type;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
  } pir_byte_type;

endpackage

/* core/pir_nvm_mem.sv */
`timescale 1ns/100ps

// Small byte store standing in for the non-volatile array; read data is registered.
module pir_nvm_mem
  import pir_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:NVM_DEPTH-1];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

/* core/pir_regs.sv */
`timescale 1ns/100ps

// How it works
// - Three-byte user revision store, writable, kept in the NVM image, loaded at reset.
// - Serial number command takes only block read and block write of three bytes.
// - Serial number is plain 24-bit writable data kept in the NVM image.
// - The NVM checksum covers the serial number bytes as well.
// - Device identifier answers a six-byte block read, byte 0 lowest; no write.
// - Device revision answers a two-byte block read; no write.
// - Revision: major in 15:12, minor in 11:8, sub-minor in 7:0.
// - Writing a read-only command sets the summary bit and status bit 7.
// - A flagged invalid command pulls the alert line to the host.
module pir_regs
  import pir_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         txn_start,
  input  wire pir_txn_type  txn,
  input  wire pir_byte_type wr_byte,
  input  wire logic         txn_end,
  input  wire logic         rd_req,
  output logic      [7:0]   rd_data,
  output logic              rd_valid,
  output logic              cmd_hit,
  output logic              busy,
  input  wire logic         store_req,
  output logic              store_done,
  input  wire logic         clear_faults,
  output logic              comm_fault_summary,
  output logic      [7:0]   comm_status_register,
  output logic              alert_n,
  output logic      [7:0]   nvm_checksum
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pir_state_type state_r;
  pir_state_type state_nxt;

  logic [47:0] live_r;
  logic [7:0]  active_code_r;
  logic        active_write_r;
  logic        active_r;
  logic [3:0]  idx_r;
  logic [7:0]  wr_len_r;
  logic [23:0] wr_buf_r;
  logic [2:0]  nvm_idx_r;
  logic        ld_capture_r;
  logic [7:0]  checksum_r;
  logic [7:0]  comm_status_r;
  logic [7:0]  rd_data_r;
  logic        rd_valid_r;
  logic        store_done_r;
  logic        alert_n_r;
  logic        hit_r;

  logic [7:0]  mem_q;
  logic        mem_we;
  logic [7:0]  cur_len;
  logic [47:0] cur_value;
  logic        cur_hit;
  logic        cur_ro;
  logic        start_ok;
  logic        inv_cmd_set;
  logic        ivd_set;
  logic        commit;

  function automatic logic [7:0] len_of(input logic [7:0] code);
    if (code == CMD_USER_REV)
      return LEN_USER_REV;
    else if (code == CMD_SERIAL)
      return LEN_SERIAL;
    else if (code == CMD_DEV_ID)
      return LEN_DEV_ID;
    else if (code == CMD_DEV_REV)
      return LEN_DEV_REV;
    else
      return 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_len   = len_of(active_code_r);
    cur_value = 48'h0000_0000_0000;
    if (active_code_r == CMD_USER_REV)
      cur_value = {24'h00_0000, live_r[23:0]};
    else if (active_code_r == CMD_SERIAL)
      cur_value = {24'h00_0000, live_r[47:24]};
    else if (active_code_r == CMD_DEV_ID)
      cur_value = DEV_ID_VALUE;
    else if (active_code_r == CMD_DEV_REV)
      cur_value = {32'h0000_0000, REV_MAJOR_VALUE, REV_MINOR_VALUE, REV_SUB_VALUE};
  end

  assign cur_hit  = (len_of(txn.code) != 8'h00);
  assign cur_ro   = (txn.code == CMD_DEV_ID) || (txn.code == CMD_DEV_REV);
  assign start_ok = txn_start && (state_r == ST_IDLE);
  assign inv_cmd_set = start_ok && cur_hit && txn.write && cur_ro;
  assign commit   = txn_end && active_r && active_write_r
                    && (wr_len_r == cur_len) && (idx_r == 4'h4);
  assign ivd_set  = txn_end && active_r && active_write_r && !commit;
  assign busy     = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Load and store sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD:
        if (ld_capture_r && nvm_idx_r == NVM_LAST)
          state_nxt = ST_IDLE;
      ST_IDLE:
        if (store_req && !active_r)
          state_nxt = ST_STORE;
      ST_STORE:
        if (nvm_idx_r == NVM_LAST)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_LOAD;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state_r <= ST_LOAD;
    else
      state_r <= state_nxt;
  end

  // The read address runs one step ahead of capture to cover the memory latency.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      nvm_idx_r    <= 3'h0;
      ld_capture_r <= 1'b0;
    end
    else if (state_r == ST_LOAD)
    begin
      ld_capture_r <= 1'b1;
      if (ld_capture_r && nvm_idx_r != NVM_LAST)
        nvm_idx_r <= nvm_idx_r + 3'h1;
    end
    else if (state_r == ST_STORE)
    begin
      ld_capture_r <= 1'b0;
      nvm_idx_r    <= (nvm_idx_r == NVM_LAST) ? 3'h0 : nvm_idx_r + 3'h1;
    end
    else
    begin
      ld_capture_r <= 1'b0;
      nvm_idx_r    <= 3'h0;
    end
  end

  assign mem_we = (state_r == ST_STORE);

  pir_nvm_mem u_nvm
  (
    .clock   (clock),
    .wr_en   (mem_we),
    .wr_addr (nvm_idx_r),
    .wr_data (live_r[8*nvm_idx_r +: 8]),
    .rd_addr ((state_r == ST_LOAD && ld_capture_r) ? nvm_idx_r + 3'h1 : nvm_idx_r),
    .rd_data (mem_q)
  );

  // Live copy: filled from the image at reset, replaced by committed writes.
  always_ff @(posedge clock)
  begin
    if (reset)
      live_r <= 48'h0000_0000_0000;
    else if (state_r == ST_LOAD && ld_capture_r)
      live_r[8*nvm_idx_r +: 8] <= mem_q;
    else if (commit && active_code_r == CMD_USER_REV)
      live_r[23:0] <= wr_buf_r;
    else if (commit && active_code_r == CMD_SERIAL)
      live_r[47:24] <= wr_buf_r;
  end

  // Sum over every image byte, serial number included.
  always_ff @(posedge clock)
  begin
    if (reset)
      checksum_r <= CHECKSUM_RESET;
    else if (state_r == ST_LOAD && ld_capture_r)
      checksum_r <= ((nvm_idx_r == NVM_USER_REV_BASE) ? 8'h00 : checksum_r) + mem_q;
    else if (state_r == ST_STORE)
      checksum_r <= ((nvm_idx_r == NVM_USER_REV_BASE) ? 8'h00 : checksum_r)
                    + live_r[8*nvm_idx_r +: 8];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      store_done_r <= 1'b0;
    else
      store_done_r <= (state_r == ST_STORE) && (nvm_idx_r == NVM_LAST);
  end

  // ----------------------------------------------------------------
  // Transaction tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      active_r       <= 1'b0;
      active_code_r  <= 8'h00;
      active_write_r <= 1'b0;
      hit_r          <= 1'b0;
    end
    else if (start_ok)
    begin
      active_r       <= cur_hit && !(txn.write && cur_ro);
      active_code_r  <= txn.code;
      active_write_r <= txn.write;
      hit_r          <= cur_hit;
    end
    else if (txn_end)
    begin
      active_r <= 1'b0;
      hit_r    <= 1'b0;
    end
  end

  // Byte 0 of a block write is the count; data follows low byte first.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      idx_r    <= 4'h0;
      wr_len_r <= 8'h00;
      wr_buf_r <= 24'h00_0000;
    end
    else if (start_ok)
      idx_r <= 4'h0;
    else if (active_r && active_write_r && wr_byte.valid)
    begin
      if (idx_r == 4'h0)
        wr_len_r <= wr_byte.data;
      else if (idx_r <= 4'h3)
        wr_buf_r[8*(idx_r-4'h1) +: 8] <= wr_byte.data;
      if (idx_r != 4'hF)
        idx_r <= idx_r + 4'h1;
    end
    else if (active_r && !active_write_r && rd_req && idx_r != 4'hF)
      idx_r <= idx_r + 4'h1;
  end

  // Block read answers the count first, then the value low byte first.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= active_r && !active_write_r && rd_req;
      if (active_r && !active_write_r && rd_req)
      begin
        if (idx_r == 4'h0)
          rd_data_r <= cur_len;
        else if ({4'h0, idx_r} <= cur_len)
          rd_data_r <= cur_value[8*(idx_r-4'h1) +: 8];
        else
          rd_data_r <= RD_FILL_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault flags and alert
  // ----------------------------------------------------------------
  // A fault that lands in the clearing cycle survives the clear.
  always_ff @(posedge clock)
  begin
    if (reset)
      comm_status_r <= COMM_STATUS_RESET;
    else
    begin
      if (clear_faults)
        comm_status_r <= COMM_STATUS_RESET;
      if (inv_cmd_set)
        comm_status_r[INVALID_CMD_BIT] <= 1'b1;
      if (ivd_set)
        comm_status_r[INVALID_DATA_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      alert_n_r <= 1'b1;
    else if (inv_cmd_set || ivd_set)
      alert_n_r <= 1'b0;
    else if (clear_faults)
      alert_n_r <= 1'b1;
  end

  assign rd_data              = rd_data_r;
  assign rd_valid             = rd_valid_r;
  assign cmd_hit              = hit_r;
  assign store_done           = store_done_r;
  assign comm_status_register = comm_status_r;
  assign comm_fault_summary   = (comm_status_r != 8'h00);
  assign alert_n              = alert_n_r;
  assign nvm_checksum         = checksum_r;

endmodule

/* testbench/pir_regs_monitor.sv */
`timescale 1ns/100ps

module pir_regs_monitor
  import pir_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        txn_start,
  input wire pir_txn_type txn,
  input wire logic        txn_end,
  input wire logic        rd_req,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic        cmd_hit,
  input wire logic        busy,
  input wire logic        store_req,
  input wire logic        clear_faults,
  input wire logic        comm_fault_summary,
  input wire logic [7:0]  comm_status_register,
  input wire logic        alert_n
);
  logic ro_wr;

  assign ro_wr = txn_start && !busy && txn.write && txn.code inside {CMD_DEV_ID, CMD_DEV_REV};

  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_id_rd;
    txn_start && !busy && !txn.write && txn.code == CMD_DEV_ID ##1 rd_req;
  endsequence

  sequence s_rev_rd;
    txn_start && !busy && !txn.write && txn.code == CMD_DEV_REV ##1 rd_req;
  endsequence

  a_id_count: assert property (s_id_rd |=> rd_valid && rd_data == LEN_DEV_ID)
    else $error("identifier count byte wrong");
  a_rev_count: assert property (s_rev_rd |=> rd_valid && rd_data == LEN_DEV_REV)
    else $error("revision count byte wrong");
  a_rd_answer: assert property (rd_req |=> rd_valid)
    else $error("read byte not answered");
  a_badcmd_flag: assert property (ro_wr |=> comm_status_register[INVALID_CMD_BIT])
    else $error("read-only write not flagged");
  a_badcmd_hold: assert property (comm_status_register[INVALID_CMD_BIT] && !clear_faults
    |=> comm_status_register[INVALID_CMD_BIT]) else $error("fault bit lost");
  a_summary_or: assert property (comm_fault_summary == (|comm_status_register))
    else $error("summary bit disagrees");
  a_alert_raise: assert property (ro_wr |=> !alert_n)
    else $error("alert not raised");
  a_clear_release: assert property (clear_faults && !txn_start && !txn_end
    |=> alert_n && comm_status_register == COMM_STATUS_RESET) else $error("clear failed");
  a_store_busy: assert property (store_req && !busy && !cmd_hit |=> busy [*6])
    else $error("store too short");
endmodule

bind pir_regs pir_regs_monitor mon (.clock, .reset, .txn_start, .txn, .txn_end, .rd_req,
  .rd_data, .rd_valid, .cmd_hit, .busy, .store_req, .clear_faults, .comm_fault_summary,
  .comm_status_register, .alert_n);

/* testbench/pir_host_model.sv */
`timescale 1ns/100ps

module pir_host_model
  import pir_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       busy,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output pir_txn_type     txn,
  output logic            txn_start,
  output pir_byte_type    wr_byte,
  output logic            txn_end,
  output logic            rd_req
);
  logic [7:0] got[$];

  initial
  begin
    txn = '0;
    txn_start = 1'b0;
    wr_byte = '0;
    txn_end = 1'b0;
    rd_req = 1'b0;
  end

  always @(posedge clock)
    if (rd_valid === 1'b1)
      got.push_back(rd_data);

  // A start while busy is silently dropped, so wait until busy is low.
  task automatic start(input logic [7:0] code, input logic wr);
    do
      @(posedge clock);
    while (busy !== 1'b0);
    got.delete();
    txn <= '{code: code, write: wr};
    txn_start <= 1'b1;
    @(posedge clock);
    txn_start <= 1'b0;
    txn <= '{code: ~code, write: ~wr};
  endtask

  task automatic wr_blk(input logic [7:0] code, input logic [7:0] q[$], input int gap);
    start(code, 1'b1);
    foreach (q[i])
    begin
      wr_byte <= '{valid: 1'b1, data: q[i]};
      @(posedge clock);
      if (gap > 0)
      begin
        wr_byte <= '{valid: 1'b0, data: ~q[i]};
        repeat (gap) @(posedge clock);
      end
    end
    wr_byte <= '{valid: 1'b0, data: ~q[q.size() - 1]};
    txn_end <= 1'b1;
    @(posedge clock);
    txn_end <= 1'b0;
  endtask

  // Closes a transaction that carried no bytes.
  task automatic end_txn;
    @(posedge clock);
    txn_end <= 1'b1;
    @(posedge clock);
    txn_end <= 1'b0;
  endtask

  task automatic rd_blk(input logic [7:0] code, input int n);
    start(code, 1'b0);
    rd_req <= 1'b1;
    repeat (n) @(posedge clock);
    rd_req <= 1'b0;
    @(posedge clock);
    txn_end <= 1'b1;
    @(posedge clock);
    txn_end <= 1'b0;
  endtask
endmodule

/* testbench/pir_regs_tb.sv */
`timescale 1ns/100ps

module pir_regs_tb
  import pir_pkg::*;
();
  localparam logic [15:0] REV_EXP = (16'(REV_MAJOR_VALUE) << REV_MAJOR_LSB)
                                  | (16'(REV_MINOR_VALUE) << REV_MINOR_LSB)
                                  | (16'(REV_SUB_VALUE) << REV_SUB_LSB);
  localparam logic [23:0] SER     = 24'hC35AE1;
  localparam logic [23:0] UREV    = 24'h1E77B4;

  logic         clock;
  logic         reset;
  logic         store_req;
  logic         clear_faults;
  logic         txn_start;
  logic         txn_end;
  logic         rd_req;
  pir_txn_type  txn;
  pir_byte_type wr_byte;
  logic [7:0]   rd_data;
  logic [7:0]   comm_status_register;
  logic [7:0]   nvm_checksum;
  logic         rd_valid;
  logic         cmd_hit;
  logic         busy;
  logic         store_done;
  logic         comm_fault_summary;
  logic         alert_n;
  int           failures;
  int           check_count;

  pir_regs dut (.clock, .reset, .txn_start, .txn, .wr_byte, .txn_end, .rd_req, .rd_data,
    .rd_valid, .cmd_hit, .busy, .store_req, .store_done, .clear_faults, .comm_fault_summary,
    .comm_status_register, .alert_n, .nvm_checksum);
  pir_host_model host (.clock, .busy, .rd_valid, .rd_data, .txn, .txn_start, .wr_byte,
    .txn_end, .rd_req);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [7:0] sum8(input logic [23:0] a, input logic [23:0] b);
    return a[7:0] + a[15:8] + a[23:16] + b[7:0] + b[15:8] + b[23:16];
  endfunction

  // One read past the payload checks the fill byte as well.
  task automatic rd_cmp(input logic [7:0] code, input logic [7:0] len, input logic [47:0] v);
    logic [7:0] e;
    host.rd_blk(code, int'(len) + 2);
    for (int i = 0; i <= len + 1; i++)
    begin
      e = (i == 0) ? len : (i > len) ? RD_FILL_BYTE : v[8*(i-1) +: 8];
      chk8(host.got[i], e);
    end
  endtask

  task automatic wr_val(input logic [7:0] code, input logic [7:0] n, input logic [23:0] v,
    input int gap);
    logic [7:0] q[$];
    q = {n, v[7:0], v[15:8], v[23:16]};
    host.wr_blk(code, q, gap);
    #1;
  endtask

  task automatic clear;
    @(posedge clock);
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic store;
    int k;
    k = 0;
    repeat (2) @(posedge clock);
    store_req <= 1'b1;
    @(posedge clock);
    store_req <= 1'b0;
    while (store_done !== 1'b1 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    chk1(store_done, 1'b1);
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic t_ids;
    rd_cmp(CMD_DEV_ID, LEN_DEV_ID, DEV_ID_VALUE);
    rd_cmp(CMD_DEV_REV, LEN_DEV_REV, {32'h0, REV_EXP});
    host.start(CMD_DEV_ID, 1'b0);
    #1;
    chk1(cmd_hit, 1'b1);
    host.end_txn();
    #1;
    chk1(cmd_hit, 1'b0);
  endtask

  task automatic t_rw;
    wr_val(CMD_SERIAL, LEN_SERIAL, SER, 2);
    rd_cmp(CMD_SERIAL, LEN_SERIAL, {24'h0, SER});
    wr_val(CMD_USER_REV, LEN_USER_REV, UREV, 0);
    rd_cmp(CMD_USER_REV, LEN_USER_REV, {24'h0, UREV});
    wr_val(CMD_SERIAL, 8'h02, 24'h0, 0);
    chk1(comm_status_register[INVALID_DATA_BIT], 1'b1);
    rd_cmp(CMD_SERIAL, LEN_SERIAL, {24'h0, SER});
    clear();
  endtask

  task automatic t_ro;
    logic [7:0] ro[2];
    ro = '{CMD_DEV_ID, CMD_DEV_REV};
    foreach (ro[i])
    begin
      wr_val(ro[i], 8'h03, 24'hFEDCBA, 0);
      chk1(comm_status_register[INVALID_CMD_BIT], 1'b1);
      chk1(comm_fault_summary, 1'b1);
      chk1(alert_n, 1'b0);
      clear();
      chk1(alert_n, 1'b1);
      chk8(comm_status_register, COMM_STATUS_RESET);
    end
    t_ids();
  endtask

  task automatic t_store;
    store();
    chk8(nvm_checksum, sum8(UREV, SER));
    wr_val(CMD_SERIAL, LEN_SERIAL, 24'h0FF03C, 0);
    store();
    chk8(nvm_checksum, sum8(UREV, 24'h0FF03C));
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd_cmp(CMD_SERIAL, LEN_SERIAL, 48'h0FF03C);
    rd_cmp(CMD_USER_REV, LEN_USER_REV, {24'h0, UREV});
  endtask

  initial
  begin
    failures = 0;
    check_count = 0;
    reset = 1'b1;
    store_req = 1'b0;
    clear_faults = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_ids();
    t_rw();
    t_ro();
    t_store();
    test_done();
  end

  initial
  begin
    #100000;
    failures++;
    test_done();
  end
endmodule
